// File: logic/gpio_first_io_port_pkg.sv
// Purpose: Shared constants and bus carriers for the first port register block.
// Assumes: AXI4-Lite with 32-bit data, five port pins.
// Notes:   Byte addresses are the full 32-bit register addresses.
`default_nettype none
package gpio_first_io_port_pkg;
  // ==========================================================================
  // Register map and fields
  // ==========================================================================
  localparam logic [31:0] REG_ADDR      = 32'hFFFF0D20;
  localparam int          PIN_COUNT     = 5;
  localparam int          DIR_LSB       = 24;
  localparam int          OUT_LSB       = 16;
  localparam int          IN_LSB        = 0;
  localparam logic [4:0]  DIR_RESET     = 5'h00;
  localparam logic [4:0]  OUT_RESET     = 5'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [3:0]  STRB_DIR_LANE = 4'h8;
  localparam logic [3:0]  STRB_OUT_LANE = 4'h4;

  // ==========================================================================
  // Bus carriers
  // ==========================================================================
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;
endpackage
`default_nettype wire

// File: logic/pin_sampler.sv
// Purpose: Registers the present pin levels for read-back.
// Assumes: Pin inputs are synchronous to sys_clk.
// Notes:   Read data come out of a register.
`timescale 1ns/1ns
`default_nettype none
module pin_sampler (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstSync_n,
  // Pin levels
  input  wire logic [4:0] pinLevel,
  output logic      [4:0] pinSample
);
  // ==========================================================================
  // Sample register
  // ==========================================================================
  logic [4:0] next_pinSample;

  always_comb begin
    next_pinSample = pinLevel;
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pinSample <= 5'h00;
    end else begin
      pinSample <= next_pinSample;
    end
  end
endmodule
`default_nettype wire

// File: logic/gpio_first_io_port_data_direction.sv
// Purpose: Data and direction register of the first I/O port over AXI4-Lite.
// Assumes: One write and one read at most under way; pins synchronous.
// Notes:   Reads of the input bits return the level sampled one cycle earlier.
//
// How it works
// - One 32-bit read/write register at fixed address.
// - Bits 28..24 set 1 make pin output.
// - Direction bit 0 makes the pin input.
// - Bits 20..16 drive output pin levels.
// - Output bits matter only for output pins.
// - Bits 4..0 read pin levels sampled one cycle earlier.
`timescale 1ns/1ns
`default_nettype none
module gpio_first_io_port_data_direction (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  // AXI4-Lite slave
  input  wire gpio_first_io_port_pkg::axi_req_t  axiReq,
  output var gpio_first_io_port_pkg::axi_rsp_t   axiRsp,
  // Port pins
  input  wire logic [4:0]                pinIn,
  output logic      [4:0]                pinOut,
  output logic      [4:0]                pinOe
);
  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rstMeta_n;
  logic rstSync_n;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // ==========================================================================
  // Pin sampling
  // ==========================================================================
  logic [4:0] pinSample;

  pin_sampler u_sampler (
    .sys_clk   (sys_clk),
    .rstSync_n (rstSync_n),
    .pinLevel  (pinIn),
    .pinSample (pinSample)
  );

  function automatic logic hit(input logic [31:0] addr);
    hit = (addr[31:2] == gpio_first_io_port_pkg::REG_ADDR[31:2]);
  endfunction

  // ==========================================================================
  // Write channel and register state
  // ==========================================================================
  logic [4:0]                dir;
  logic [4:0]                dout;
  logic [4:0]                next_dir;
  logic [4:0]                next_dout;
  logic                      awHeld;
  logic                      wHeld;
  logic [31:0]               awAddr;
  logic [31:0]               wData;
  logic [3:0]                wStrb;
  logic                      next_awHeld;
  logic                      next_wHeld;
  logic [31:0]               next_awAddr;
  logic [31:0]               next_wData;
  logic [3:0]                next_wStrb;
  logic                      bValid;
  logic [1:0]                bResp;
  logic                      next_bValid;
  logic [1:0]                next_bResp;
  gpio_first_io_port_pkg::wr_state_t wrState;
  gpio_first_io_port_pkg::wr_state_t next_wrState;
  logic                      awReady;
  logic                      wReady;

  always_comb begin
    next_dir     = dir;
    next_dout    = dout;
    next_awHeld  = awHeld;
    next_wHeld   = wHeld;
    next_awAddr  = awAddr;
    next_wData   = wData;
    next_wStrb   = wStrb;
    next_bValid  = bValid;
    next_bResp   = bResp;
    next_wrState = wrState;
    case (wrState)
      gpio_first_io_port_pkg::WR_IDLE: begin
        if (axiReq.awvalid && !awHeld) begin
          next_awHeld = 1'b1;
          next_awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && !wHeld) begin
          next_wHeld = 1'b1;
          next_wData = axiReq.wdata;
          next_wStrb = axiReq.wstrb;
        end
        if (awHeld && wHeld) begin
          next_awHeld  = 1'b0;
          next_wHeld   = 1'b0;
          next_bValid  = 1'b1;
          next_wrState = gpio_first_io_port_pkg::WR_RESP;
          if (hit(awAddr)) begin
            next_bResp = gpio_first_io_port_pkg::RESP_OKAY;
            // Input and reserved bits are dropped; only two lanes hold state.
            if ((wStrb & gpio_first_io_port_pkg::STRB_DIR_LANE) != 4'h0) begin
              next_dir = wData[gpio_first_io_port_pkg::DIR_LSB +: gpio_first_io_port_pkg::PIN_COUNT];
            end
            if ((wStrb & gpio_first_io_port_pkg::STRB_OUT_LANE) != 4'h0) begin
              next_dout = wData[gpio_first_io_port_pkg::OUT_LSB +: gpio_first_io_port_pkg::PIN_COUNT];
            end
          end else begin
            next_bResp = gpio_first_io_port_pkg::RESP_SLVERR;
          end
        end
      end
      gpio_first_io_port_pkg::WR_RESP: begin
        if (axiReq.bready) begin
          next_bValid  = 1'b0;
          next_wrState = gpio_first_io_port_pkg::WR_IDLE;
        end
      end
      default: begin
        next_wrState = gpio_first_io_port_pkg::WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      dir     <= gpio_first_io_port_pkg::DIR_RESET;
      dout    <= gpio_first_io_port_pkg::OUT_RESET;
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      awAddr  <= 32'h00000000;
      wData   <= 32'h00000000;
      wStrb   <= 4'h0;
      bValid  <= 1'b0;
      bResp   <= 2'h0;
      wrState <= gpio_first_io_port_pkg::WR_IDLE;
    end else begin
      dir     <= next_dir;
      dout    <= next_dout;
      awHeld  <= next_awHeld;
      wHeld   <= next_wHeld;
      awAddr  <= next_awAddr;
      wData   <= next_wData;
      wStrb   <= next_wStrb;
      bValid  <= next_bValid;
      bResp   <= next_bResp;
      wrState <= next_wrState;
    end
  end

  // Ready is a registered term: high while idle and the channel slot is free.
  logic next_awReady;
  logic next_wReady;

  always_comb begin
    next_awReady = (next_wrState == gpio_first_io_port_pkg::WR_IDLE) && !next_awHeld;
    next_wReady  = (next_wrState == gpio_first_io_port_pkg::WR_IDLE) && !next_wHeld;
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      awReady <= 1'b0;
      wReady  <= 1'b0;
    end else begin
      awReady <= next_awReady;
      wReady  <= next_wReady;
    end
  end

  // ==========================================================================
  // Read channel
  // ==========================================================================
  logic        arReady;
  logic        rValid;
  logic [31:0] rData;
  logic [1:0]  rResp;
  logic        next_arReady;
  logic        next_rValid;
  logic [31:0] next_rData;
  logic [1:0]  next_rResp;

  always_comb begin
    next_arReady = arReady;
    next_rValid  = rValid;
    next_rData   = rData;
    next_rResp   = rResp;
    if (rValid) begin
      if (axiReq.rready) begin
        next_rValid  = 1'b0;
        next_arReady = 1'b1;
      end
    end else if (axiReq.arvalid && arReady) begin
      next_arReady = 1'b0;
      next_rValid  = 1'b1;
      next_rData   = 32'h00000000;
      if (hit(axiReq.araddr)) begin
        next_rResp = gpio_first_io_port_pkg::RESP_OKAY;
        next_rData[gpio_first_io_port_pkg::DIR_LSB +: gpio_first_io_port_pkg::PIN_COUNT] = dir;
        next_rData[gpio_first_io_port_pkg::OUT_LSB +: gpio_first_io_port_pkg::PIN_COUNT] = dout;
        next_rData[gpio_first_io_port_pkg::IN_LSB +: gpio_first_io_port_pkg::PIN_COUNT]  = pinSample;
      end else begin
        next_rResp = gpio_first_io_port_pkg::RESP_SLVERR;
      end
    end else begin
      next_arReady = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      arReady <= 1'b0;
      rValid  <= 1'b0;
      rData   <= 32'h00000000;
      rResp   <= 2'h0;
    end else begin
      arReady <= next_arReady;
      rValid  <= next_rValid;
      rData   <= next_rData;
      rResp   <= next_rResp;
    end
  end

  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  logic [4:0] next_pinOut;
  logic [4:0] next_pinOe;

  always_comb begin
    next_pinOe  = next_dir;
    next_pinOut = next_dout & next_dir;
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pinOe  <= gpio_first_io_port_pkg::DIR_RESET;
      pinOut <= 5'h00;
    end else begin
      pinOe  <= next_pinOe;
      pinOut <= next_pinOut;
    end
  end

  always_comb begin
    axiRsp.awready = awReady;
    axiRsp.wready  = wReady;
    axiRsp.bvalid  = bValid;
    axiRsp.bresp   = bResp;
    axiRsp.arready = arReady;
    axiRsp.rvalid  = rValid;
    axiRsp.rdata   = rData;
    axiRsp.rresp   = rResp;
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence rdHit;
    axiReq.arvalid && arReady && !rValid && hit(axiReq.araddr);
  endsequence

  dir_drives_oe_a: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
    pinOe == dir) else $error("Output enable differs from direction.");
  input_hiz_a: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
    (dir == 5'h00) |-> (pinOe == 5'h00)) else $error("Input pin driven.");
  out_level_a: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
    pinOut == (dout & dir)) else $error("Pin level differs from output bit.");
  masked_out_a: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
    (pinOut & ~pinOe) == 5'h00) else $error("Undriven pin shows level.");
  read_pins_a: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
    rdHit |=> rValid && (rData[4:0] == $past(pinSample)))
    else $error("Read input bits wrong.");
  read_fields_a: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
    rdHit |=> (rData[28:24] == $past(dir))
    && (rResp == gpio_first_io_port_pkg::RESP_OKAY)) else $error("Read register wrong.");
  write_resp_a: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
    (wrState == gpio_first_io_port_pkg::WR_IDLE) && awHeld && wHeld |=> bValid)
    else $error("Write response missing.");
  dir_stable_a: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
    !(awHeld && wHeld) |=> $stable(dir) && $stable(dout))
    else $error("State changed without write.");
endmodule
`default_nettype wire

// File: test/pin_model.sv
// Purpose: Model of the five external pins of the first port.
// Assumes: An outside source drives each pin while the port does not.
// Notes:   The wire level is resolved from the port's enable alone.
`timescale 1ns/1ns
`default_nettype none
module pin_model (
  // Port side
  input  wire logic [4:0] pinOut,
  input  wire logic [4:0] pinOe,
  // Outside source
  input  wire logic [4:0] extLevel,
  // Resolved level
  output logic      [4:0] pinIn
);
  // ==========================================================================
  // Wire resolution
  // ==========================================================================
  // Each pin carries the port's level while enabled, else the outside level.
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pinIn[i] = pinOe[i] ? pinOut[i] : extLevel[i];
    end
  end
endmodule
`default_nettype wire

// File: test/gpio_first_io_port_data_direction_test.sv
// Purpose: Self-checking bench of the first port register block.
// Assumes: AXI4-Lite master tasks; pins resolved by the pin model.
// Notes:   Writes keep the input and reserved bits at zero.
`timescale 1ns/1ns
`default_nettype none
module gpio_first_io_port_data_direction_test;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic                     sys_clk;
  logic                     arst_n;
  gpio_first_io_port_pkg::axi_req_t axiReq;
  gpio_first_io_port_pkg::axi_rsp_t axiRsp;
  logic [4:0]               pinIn;
  logic [4:0]               pinOut;
  logic [4:0]               pinOe;
  logic [4:0]               extLevel;
  int                       nMismatch;
  int                       numChecks;
  int                       cycles;
  localparam logic [31:0]   A = gpio_first_io_port_pkg::REG_ADDR;

  gpio_first_io_port_data_direction u_gpio_first_io_port_data_direction (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .axiReq  (axiReq),
    .axiRsp  (axiRsp),
    .pinIn   (pinIn),
    .pinOut  (pinOut),
    .pinOe   (pinOe)
  );

  pin_model u_pin_model (
    .pinOut   (pinOut),
    .pinOe    (pinOe),
    .extLevel (extLevel),
    .pinIn    (pinIn)
  );

  // ==========================================================================
  // Clock and timeout
  // ==========================================================================
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      nMismatch++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                           input logic [3:0] s, input logic [1:0] er);
    @(posedge sys_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr  <= a;
    axiReq.wvalid  <= 1'b1;
    axiReq.wdata   <= d;
    axiReq.wstrb   <= s;
    axiReq.bready  <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid) begin
        check({30'h0, axiRsp.bresp}, {30'h0, er});
        axiReq.bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_read(input logic [31:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    @(posedge sys_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr  <= a;
    axiReq.rready  <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid) begin
        check(axiRsp.rdata, ed);
        check({30'h0, axiRsp.rresp}, {30'h0, er});
        axiReq.rready <= 1'b0;
        break;
      end
    end
  endtask

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    nMismatch = 0;
    numChecks = 0;
    cycles    = 0;
    arst_n    = 1'b0;
    axiReq    = '0;
    extLevel  = 5'h15;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Reset state: all pins inputs, status shows the outside levels.
    check({27'h0, pinOe}, 32'h00000000);
    axi_read(A, 32'h00000015, gpio_first_io_port_pkg::RESP_OKAY);
    // All pins outputs, driven from the output bits.
    axi_write(A, 32'h1F0A0000, 4'hF, gpio_first_io_port_pkg::RESP_OKAY);
    check({27'h0, pinOe}, 32'h0000001F);
    check({27'h0, pinOut}, 32'h0000000A);
    axi_read(A, 32'h1F0A000A, gpio_first_io_port_pkg::RESP_OKAY);
    // Mixed directions: inputs read the outside level.
    extLevel <= 5'h0A;
    axi_write(A, 32'h051F0000, 4'hF, gpio_first_io_port_pkg::RESP_OKAY);
    check({27'h0, pinOut}, 32'h00000005);
    axi_read(A, 32'h051F000F, gpio_first_io_port_pkg::RESP_OKAY);
    // Output lane only; the direction lane is left alone.
    axi_write(A, 32'h1F000000, gpio_first_io_port_pkg::STRB_OUT_LANE,
              gpio_first_io_port_pkg::RESP_OKAY);
    axi_read(A, 32'h0500000A, gpio_first_io_port_pkg::RESP_OKAY);
    // Unmapped address is refused and leaves the register alone.
    axi_write(A + 32'h4, 32'h1F1F0000, 4'hF, gpio_first_io_port_pkg::RESP_SLVERR);
    axi_read(A + 32'h4, 32'h00000000, gpio_first_io_port_pkg::RESP_SLVERR);
    axi_read(A, 32'h0500000A, gpio_first_io_port_pkg::RESP_OKAY);
    // Back to all inputs, back to back.
    extLevel <= 5'h15;
    axi_write(A, 32'h00000000, 4'hF, gpio_first_io_port_pkg::RESP_OKAY);
    check({27'h0, pinOe}, 32'h00000000);
    axi_read(A, 32'h00000015, gpio_first_io_port_pkg::RESP_OKAY);
    report_and_stop();
  end
endmodule
`default_nettype wire
